// [shared/brgc_pkg.sv]
//==============================================================
// Behaviour
// - Request bit write starts reset, then initialisation
// - Request write also overwrites holdoff flag, gap
// - Sent or received config packet loads both, except in a cycle with a register write
// - Two unmodified resets force gap to 63
// - Own requested reset keeps the written gap
//==============================================================
package brgc_pkg;
  // Field widths
  localparam int GAP_W = 6;
  localparam int TMR_W = 16;
  localparam int CNT_W = 2;
  // Largest gap count, also its reset value
  localparam logic [GAP_W-1:0] GAP_MAX = 6'h3F;
  localparam logic [GAP_W-1:0] GAP_RST = 6'h3F;
  // Holdoff flag reset value
  localparam logic RHF_RST = 1'h0;
  // Unmodified resets before the gap is forced
  localparam logic [CNT_W-1:0] RST_LIMIT = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  // Default phase lengths in clock cycles
  localparam logic [TMR_W-1:0] DEF_RESET_CYCLES = 16'h0010;
  localparam logic [TMR_W-1:0] DEF_INIT_CYCLES = 16'h0020;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
  // Bus reset sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESET = 2'b01,
    ST_INIT = 2'b10
  } brgc_state_t;
endpackage

// [shared/brgc_if.sv]
`timescale 1ns/1ps
//==============================================================
// Carrier between sequencer and gap tracker
//==============================================================
interface brgc_if;
  // Update strobe with the values to load
  logic upd;
  logic upd_rhf;
  logic [brgc_pkg::GAP_W-1:0] upd_gap;
  // Start of any bus reset
  logic brst_evt;
  // Held values
  logic rhf;
  logic [brgc_pkg::GAP_W-1:0] gap;
  // Sequencer side
  modport ctl (output upd, output upd_rhf, output upd_gap, output brst_evt, input rhf, input gap);
  // Tracker side
  modport trk (input upd, input upd_rhf, input upd_gap, input brst_evt, output rhf, output gap);
endinterface

// [hdl/brgc_gap_track.sv]
`timescale 1ns/1ps
//==============================================================
// Holdoff flag and gap count with reset-count recovery
//==============================================================
module brgc_gap_track (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link to sequencer
  brgc_if.trk trk
);
  // Consecutive resets without update
  logic [brgc_pkg::CNT_W-1:0] cnt_r;
  logic [brgc_pkg::CNT_W-1:0] cnt_nxt;
  // Held flag and gap
  // six-bit gap, one-bit flag
  logic rhf_r;
  logic [brgc_pkg::GAP_W-1:0] gap_r;
  logic [brgc_pkg::GAP_W-1:0] gap_nxt;
  // Reset that reaches the limit
  wire force_max;
  wire cnt_full;

  //==============================================================
  // Next-value decode
  //==============================================================
  assign cnt_full = (cnt_r >= brgc_pkg::RST_LIMIT);
  assign force_max = trk.brst_evt && !trk.upd && (cnt_r >= brgc_pkg::RST_LIMIT - brgc_pkg::CNT_ONE);
  assign cnt_nxt = trk.upd ? (trk.brst_evt ? brgc_pkg::CNT_ONE : brgc_pkg::CNT_ZERO) :
                   (trk.brst_evt && !cnt_full) ? cnt_r + brgc_pkg::CNT_ONE : cnt_r;
  assign gap_nxt = trk.upd ? trk.upd_gap : (force_max ? brgc_pkg::GAP_MAX : gap_r);

  //==============================================================
  // State registers
  //==============================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Reset values
      cnt_r <= brgc_pkg::CNT_ZERO;
      rhf_r <= brgc_pkg::RHF_RST;
      gap_r <= brgc_pkg::GAP_RST;
    end else begin
      // Count, flag and gap
      cnt_r <= cnt_nxt;
      gap_r <= gap_nxt;
      if (trk.upd) begin
        rhf_r <= trk.upd_rhf;
      end
    end
  end

  // Outputs to sequencer
  assign trk.rhf = rhf_r;
  assign trk.gap = gap_r;

  //==============================================================
  // Checks
  //==============================================================
  property p_second_reset_forces;
    @(posedge sys_clk) disable iff (rst)
    (trk.brst_evt && !trk.upd) ##1 (trk.brst_evt && !trk.upd) |=> (gap_r == brgc_pkg::GAP_MAX);
  endproperty
  a_second_reset_forces: assert property (p_second_reset_forces)
    else $error("gap not forced after two resets");

  property p_single_reset_keeps;
    @(posedge sys_clk) disable iff (rst)
    (trk.upd && !trk.brst_evt) ##1 (!trk.upd && !trk.brst_evt) ##1
      (trk.brst_evt && !trk.upd) |=> $stable(gap_r);
  endproperty
  a_single_reset_keeps: assert property (p_single_reset_keeps)
    else $error("gap changed on first reset after update");
endmodule

// [hdl/brgc_top.sv]
`timescale 1ns/1ps
//==============================================================
// Bus reset request and gap count control
//==============================================================
module brgc_top #(
  // Length of the reset phase in cycles
  parameter logic [brgc_pkg::TMR_W-1:0] RESET_CYCLES = brgc_pkg::DEF_RESET_CYCLES,
  // Length of the initialisation phase in cycles
  parameter logic [brgc_pkg::TMR_W-1:0] INIT_CYCLES = brgc_pkg::DEF_INIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register one write port
  input wire logic phy_wr_en,
  input wire logic wr_reset_request_bit,
  input wire logic wr_root_holdoff_flag,
  input wire logic [brgc_pkg::GAP_W-1:0] wr_gap_count,
  // Config packet received or sent
  input wire logic cfg_rx_en,
  input wire logic cfg_tx_en,
  input wire logic cfg_root_holdoff_flag,
  input wire logic [brgc_pkg::GAP_W-1:0] cfg_gap_count,
  // Bus reset seen on the cable
  input wire logic bus_reset_in,
  // Held register values
  output logic root_holdoff_flag,
  output logic [brgc_pkg::GAP_W-1:0] gap_count,
  // Reset sequence status
  output logic bus_reset_start,
  output logic bus_reset_active,
  output logic bus_init_active
);
  // Carrier to the tracker
  brgc_if bif ();

  // Sequencer state
  brgc_pkg::brgc_state_t state_r;
  brgc_pkg::brgc_state_t state_nxt;
  // Phase timer
  logic [brgc_pkg::TMR_W-1:0] tmr_r;
  logic [brgc_pkg::TMR_W-1:0] tmr_nxt;
  // Output flops
  logic start_r;
  logic rst_act_r;
  logic init_act_r;

  // Request from the register write
  wire req_go;
  // Any reason to begin a reset
  wire start_now;
  // Any config packet event
  wire cfg_go;
  // Timer at end of phase
  wire tmr_done;

  //==============================================================
  // Request and update decode
  //==============================================================
  // request bit decode
  assign req_go = phy_wr_en && wr_reset_request_bit;
  assign start_now = req_go || bus_reset_in;
  assign cfg_go = cfg_rx_en || cfg_tx_en;
  assign tmr_done = (tmr_r == brgc_pkg::TMR_ZERO);

  assign bif.upd = phy_wr_en || cfg_go;
  assign bif.upd_rhf = phy_wr_en ? wr_root_holdoff_flag : cfg_root_holdoff_flag;
  assign bif.upd_gap = phy_wr_en ? wr_gap_count : cfg_gap_count;
  // Every reset start is counted
  assign bif.brst_evt = start_now;

  //==============================================================
  // Gap tracker
  //==============================================================
  brgc_gap_track u_track (
    .sys_clk (sys_clk),
    .rst (rst),
    .trk (bif.trk)
  );

  //==============================================================
  // Reset sequencer next state
  //==============================================================
  always_comb begin
    // Hold by default
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    case (state_r)
      brgc_pkg::ST_IDLE: begin
        if (start_now) begin
          state_nxt = brgc_pkg::ST_RESET;
          tmr_nxt = RESET_CYCLES - brgc_pkg::TMR_ONE;
        end
      end
      brgc_pkg::ST_RESET: begin
        // New request restarts the phase
        if (start_now) begin
          tmr_nxt = RESET_CYCLES - brgc_pkg::TMR_ONE;
        end else if (tmr_done) begin
          state_nxt = brgc_pkg::ST_INIT;
          tmr_nxt = INIT_CYCLES - brgc_pkg::TMR_ONE;
        end else begin
          tmr_nxt = tmr_r - brgc_pkg::TMR_ONE;
        end
      end
      brgc_pkg::ST_INIT: begin
        // Reset during init starts over
        if (start_now) begin
          state_nxt = brgc_pkg::ST_RESET;
          tmr_nxt = RESET_CYCLES - brgc_pkg::TMR_ONE;
        end else if (tmr_done) begin
          state_nxt = brgc_pkg::ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - brgc_pkg::TMR_ONE;
        end
      end
      default: begin
        // Recover from illegal code
        state_nxt = brgc_pkg::ST_IDLE;
        tmr_nxt = brgc_pkg::TMR_ZERO;
      end
    endcase
  end

  //==============================================================
  // Sequencer registers
  //==============================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= brgc_pkg::ST_IDLE;
      tmr_r <= brgc_pkg::TMR_ZERO;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // Status flops, aligned with state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_r <= 1'h0;
      rst_act_r <= 1'h0;
      init_act_r <= 1'h0;
    end else begin
      start_r <= start_now;
      rst_act_r <= (state_nxt == brgc_pkg::ST_RESET);
      init_act_r <= (state_nxt == brgc_pkg::ST_INIT);
    end
  end

  //==============================================================
  // Outputs
  //==============================================================
  assign bus_reset_start = start_r;
  assign bus_reset_active = rst_act_r;
  assign bus_init_active = init_act_r;
  // Tracker flops pass straight out
  assign root_holdoff_flag = bif.rhf;
  assign gap_count = bif.gap;

  //==============================================================
  // Checks
  //==============================================================
  property p_req_starts_reset;
    @(posedge sys_clk) disable iff (rst)
    req_go |=> (bus_reset_start && bus_reset_active && !bus_init_active);
  endproperty
  a_req_starts_reset: assert property (p_req_starts_reset)
    else $error("request did not start bus reset");

  property p_reset_then_init;
    @(posedge sys_clk) disable iff (rst)
    $fell(bus_reset_active) && !$past(rst) |-> bus_init_active;
  endproperty
  a_reset_then_init: assert property (p_reset_then_init)
    else $error("reset phase not followed by init");

  property p_write_loads;
    @(posedge sys_clk) disable iff (rst)
    phy_wr_en |=> (gap_count == $past(wr_gap_count)) && (root_holdoff_flag == $past(wr_root_holdoff_flag));
  endproperty
  a_write_loads: assert property (p_write_loads)
    else $error("write did not load holdoff and gap");

  property p_cfg_loads;
    @(posedge sys_clk) disable iff (rst)
    (cfg_go && !phy_wr_en) |=> (gap_count == $past(cfg_gap_count)) &&
      (root_holdoff_flag == $past(cfg_root_holdoff_flag));
  endproperty
  a_cfg_loads: assert property (p_cfg_loads)
    else $error("config packet did not load holdoff and gap");

  property p_own_reset_keeps;
    @(posedge sys_clk) disable iff (rst)
    req_go ##1 (!phy_wr_en && !cfg_go && !bus_reset_in) [*3] |=> (gap_count == $past(gap_count, 3));
  endproperty
  a_own_reset_keeps: assert property (p_own_reset_keeps)
    else $error("own reset changed the written gap");
endmodule

// [testbench/brgc_peer_model.sv]
`timescale 1ns/1ps
//==============================================================
// Cable side: packets and bus resets from peers
//==============================================================
module brgc_peer_model (
  // Clock
  input wire logic sys_clk,
  // Pulses toward the block
  output logic cfg_rx_en,
  output logic cfg_tx_en,
  output logic cfg_root_holdoff_flag,
  output logic [brgc_pkg::GAP_W-1:0] cfg_gap_count,
  output logic bus_reset_in
);
  // Idle at time zero
  initial begin
    cfg_rx_en = 1'h0;
    cfg_tx_en = 1'h0;
    cfg_root_holdoff_flag = 1'h1;
    cfg_gap_count = 6'h2A;
    bus_reset_in = 1'h0;
  end
  task automatic send_pkt(input logic tx, input logic rhf, input logic [5:0] gap);
    cfg_rx_en = !tx;
    cfg_tx_en = tx;
    cfg_root_holdoff_flag = rhf;
    cfg_gap_count = gap;
    @(negedge sys_clk);
    cfg_rx_en = 1'h0;
    cfg_tx_en = 1'h0;
    // Released lines show the inverse
    cfg_root_holdoff_flag = !rhf;
    cfg_gap_count = ~gap;
  endtask
  // New connection pulses a bus reset
  task automatic new_conn(input int len);
    bus_reset_in = 1'h1;
    repeat (len) @(negedge sys_clk);
    bus_reset_in = 1'h0;
  endtask
endmodule

// [testbench/brgc_top_tb_top.sv]
`timescale 1ns/1ps
//==============================================================
// Bench for bus reset and gap count control
//==============================================================
module brgc_top_tb_top;
  typedef struct {logic [5:0] gap; logic rhf; logic st; int due;} brgc_note_t;
  localparam logic [15:0] RST_CYC = 16'h0004;
  localparam logic [15:0] INI_CYC = 16'h0004;
  // Design pins
  logic sys_clk = 1'h0, rst = 1'h1, phy_wr_en = 1'h0, wr_rq = 1'h0, wr_rhf = 1'h0;
  logic [5:0] wr_gap = 6'h00, cfg_gap, gap_count;
  logic cfg_rx_en, cfg_tx_en, cfg_rhf, bus_reset_in;
  logic root_holdoff_flag, bus_reset_start, bus_reset_active, bus_init_active;
  // Bench state
  int failures = 0, check_count = 0, cyc = 0, rst_cnt = 0;
  logic [5:0] exp_gap = 6'h3F, g;
  logic exp_rhf = 1'h0;
  brgc_note_t exp_q[$], n;
  always #2.5 sys_clk = !sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  brgc_top #(.RESET_CYCLES(RST_CYC), .INIT_CYCLES(INI_CYC)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .phy_wr_en(phy_wr_en), .wr_reset_request_bit(wr_rq), .wr_root_holdoff_flag(wr_rhf),
    .wr_gap_count(wr_gap), .cfg_rx_en(cfg_rx_en), .cfg_tx_en(cfg_tx_en), .cfg_root_holdoff_flag(cfg_rhf),
    .cfg_gap_count(cfg_gap), .bus_reset_in(bus_reset_in), .root_holdoff_flag(root_holdoff_flag),
    .gap_count(gap_count), .bus_reset_start(bus_reset_start), .bus_reset_active(bus_reset_active),
    .bus_init_active(bus_init_active));
  brgc_peer_model u_peer (.sys_clk(sys_clk), .cfg_rx_en(cfg_rx_en), .cfg_tx_en(cfg_tx_en),
    .cfg_root_holdoff_flag(cfg_rhf), .cfg_gap_count(cfg_gap), .bus_reset_in(bus_reset_in));
  //==============================================================
  // Compare and note helpers
  //==============================================================
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic note(input logic st);
    exp_q.push_back('{exp_gap, exp_rhf, st, cyc + 1});
  endtask
  // Register write; a cause with an update counts one reset
  task automatic reg_wr(input logic rq, input logic rhf, input logic [5:0] gap);
    @(negedge sys_clk);
    phy_wr_en = 1'h1;
    wr_rq = rq;
    wr_rhf = rhf;
    wr_gap = gap;
    exp_gap = gap;
    exp_rhf = rhf;
    rst_cnt = rq;
    note(rq);
    @(negedge sys_clk);
    phy_wr_en = 1'h0;
    wr_rq = 1'h0;
    wr_gap = ~gap;
  endtask
  task automatic pkt(input logic tx, input logic rhf, input logic [5:0] gap);
    @(negedge sys_clk);
    exp_gap = gap;
    exp_rhf = rhf;
    rst_cnt = 0;
    note(1'h0);
    u_peer.send_pkt(tx, rhf, gap);
  endtask
  // Cable reset held len cycles; each cycle counts one reset
  task automatic cable_rst(input int len);
    int k;
    @(negedge sys_clk);
    for (k = 1; k <= len; k++) begin
      rst_cnt++;
      if (rst_cnt >= 2) exp_gap = 6'h3F;
      exp_q.push_back('{exp_gap, exp_rhf, 1'h1, cyc + k});
    end
    u_peer.new_conn(len);
  endtask
  // Reset then initialisation phase lengths
  task automatic seq_chk();
    cmp(bus_reset_active, 1'h1, "reset phase on");
    repeat (RST_CYC) @(negedge sys_clk);
    cmp({bus_reset_active, bus_init_active}, 8'h01, "init phase on");
    repeat (INI_CYC) @(negedge sys_clk);
    cmp(bus_init_active, 1'h0, "init phase off");
  endtask
  // Monitor takes due notes off the queue
  always @(negedge sys_clk) begin
    while (exp_q.size() > 0 && exp_q[0].due == cyc) begin
      n = exp_q.pop_front();
      cmp(gap_count, n.gap, "gap count");
      cmp(root_holdoff_flag, n.rhf, "holdoff flag");
      cmp(bus_reset_start, n.st, "reset start");
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  //==============================================================
  // Tests
  //==============================================================
  initial begin
    g = $urandom(40);
    repeat (3) @(negedge sys_clk);
    rst = 1'h0;
    g = 6'($urandom);
    reg_wr(1'h1, 1'h1, g);
    seq_chk();
    cmp(gap_count, g, "own reset keeps gap");
    cable_rst(1);
    seq_chk();
    $display("test request reset done");
    pkt(1'h1, 1'h0, 6'h05);
    reg_wr(1'h1, root_holdoff_flag, gap_count);
    cable_rst(1);
    pkt(1'h0, 1'h1, 6'h11);
    cable_rst(1);
    cable_rst(1);
    reg_wr(1'h1, root_holdoff_flag, 6'h3F);
    reg_wr(1'h0, 1'h0, 6'h09);
    cable_rst(1);
    $display("test packets done");
    repeat (4) begin
      pkt(1'($urandom), 1'($urandom), 6'($urandom));
      reg_wr(1'h1, root_holdoff_flag, gap_count);
    end
    cable_rst(2);
    @(negedge sys_clk);
    rst = 1'h1;
    @(negedge sys_clk);
    rst = 1'h0;
    cmp({root_holdoff_flag, gap_count}, 8'h3F, "reset values");
    exp_gap = 6'h3F;
    exp_rhf = 1'h0;
    rst_cnt = 0;
    reg_wr(1'h1, root_holdoff_flag, 6'h3F);
    seq_chk();
    $display("test random and reset done");
    give_verdict();
  end
endmodule
